// ===== rtl/serial_register_access_port.sv
// serial register access port with buffered settings registers
module serial_register_access_port (
  // system clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  // mode straps
  input wire logic strap_pin_a,
  input wire logic strap_pin_b,
  input wire logic strap_pin_c,
  input wire logic strap_pin_d,
  // multifunction pin used as update trigger
  input wire logic update_pin,
  // serial link
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_output_pin,
  output logic serial_output_oe,
  // device side
  output logic port_enabled,
  output logic [127:0] active_settings
);

  // ==========================================================================
  // operating notes
  //
  // two clock domains
  //   link side runs on serial_clock
  //   system side runs on clock
  //   clock_enable gates the system side only
  //
  // frame framing
  //   select low opens a frame
  //   select high clears all frame state at once
  //   no byte count, frame length set by host
  //   first sixteen rises carry the instruction
  //   top instruction bit gives direction
  //   set direction bit means read
  //   low thirteen bits give start address
  //   two address bits above those are dropped
  //
  // bit order
  //   msb first after reset
  //   lsb first once config bit six is set
  //   order applies to instruction and payload
  //   config writes act from the next byte on
  //
  // address stepping
  //   one step after every full byte
  //   ascension bit alone picks the direction
  //   thirteen-bit wrap at either end
  //   unmapped addresses never skipped
  //
  // writes
  //   full byte handed over with a toggle
  //   toggle crosses through three flip-flops
  //   address and data held for a whole byte
  //   byte period far longer than the crossing
  //   partial byte at select rise never handed over
  //   control registers stay on the link side
  //   settings writes land in buffers only
  //
  // update
  //   bit zero write to trigger register commits
  //   trigger register itself reads zero
  //   update pin rising edge commits too
  //   pin commit waits for a closed frame
  //   buffers copied to active in one clock
  //
  // reads
  //   bit loaded after every falling edge
  //   first bit after the sixteenth rise
  //   new byte fetched at each byte boundary
  //   readback source picked by select bit five
  //   unmapped addresses read as zero
  //
  // pins
  //   three-wire drives the shared data pin
  //   four-wire drives the separate output pin
  //   both enables low while select is high
  //   nothing driven while port disabled
  //
  // straps
  //   synchronised, then sampled once
  //   sampled a few clocks after reset release
  //   choice fixed until the next reset
  //
  // hazards
  //   settings readback crosses domains unsynchronised
  //   host must not read a byte while it is written
  //   allow a few clocks between dependent frames
  //

  // ==========================================================================
  // declarations
  localparam int IDX_BITS = $clog2(serial_port_pkg::SETTINGS_COUNT);


  logic [7:0] serial_port_config;
  logic [7:0] readback_source_select;
  logic [3:0] bit_count;
  logic instr_done;
  logic is_read;
  logic [12:0] addr;
  logic [14:0] instr_shift;
  logic [6:0] byte_shift;
  logic [2:0] payload_bit;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_toggle;
  logic [7:0] tx_shift;
  logic tx_bit;
  logic tx_active;
  logic [7:0] buffer_regs [serial_port_pkg::SETTINGS_COUNT];
  logic [7:0] active_regs [serial_port_pkg::SETTINGS_COUNT];
  logic [2:0] wr_sync;
  logic [1:0] select_sync;
  logic [1:0] update_sync;
  logic update_seen;
  logic update_pending;
  logic [3:0] strap_meta;
  logic [3:0] strap_sync;
  logic [1:0] strap_settle;
  logic strap_done;

  // ==========================================================================
  // link side decoding
  wire frame_clear_n = resetn & ~chip_select_n;
  wire lsb_first = serial_port_config[serial_port_pkg::LSB_FIRST_POS];
  wire ascend = serial_port_config[serial_port_pkg::ASCEND_POS];
  wire four_wire = serial_port_config[serial_port_pkg::FOUR_WIRE_POS];
  wire [15:0] instr_word = lsb_first ? {sdio_in, instr_shift} : {instr_shift, sdio_in};
  wire [7:0] byte_word = lsb_first ? {sdio_in, byte_shift} : {byte_shift, sdio_in};
  wire instr_last = !instr_done && bit_count == serial_port_pkg::INSTR_LAST;
  wire byte_last = instr_done && payload_bit == serial_port_pkg::BYTE_LAST;
  wire write_byte = byte_last && !is_read && port_enabled;
  // direction from ascension bit only
  wire [12:0] next_addr = ascend ? addr + 13'h0001 : addr - 13'h0001;

  // ==========================================================================
  // readback selection, includes unused addresses
  wire [12:0] settings_offset = addr - serial_port_pkg::SETTINGS_BASE_OFFSET;
  wire in_settings = addr >= serial_port_pkg::SETTINGS_BASE_OFFSET &&
    settings_offset < 13'(serial_port_pkg::SETTINGS_COUNT);
  wire [IDX_BITS-1:0] rd_index = settings_offset[IDX_BITS-1:0];
  wire read_active = readback_source_select[serial_port_pkg::READ_ACTIVE_POS];
  wire [7:0] settings_byte = read_active ? active_regs[rd_index] : buffer_regs[rd_index];
  wire is_config = addr == serial_port_pkg::SERIAL_PORT_CONFIG_OFFSET;
  wire is_select = addr == serial_port_pkg::READBACK_SOURCE_SELECT_OFFSET;
  // unmapped and trigger addresses read as zero
  wire [7:0] rd_byte = is_config ? serial_port_config :
    is_select ? readback_source_select :
    in_settings ? settings_byte : 8'h00;

  // ==========================================================================
  // instruction and payload receive, cleared whenever select is high
  always_ff @(posedge serial_clock or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      bit_count <= 4'h0;
      instr_done <= 1'b0;
      is_read <= 1'b0;
      addr <= 13'h0000;
      instr_shift <= 15'h0000;
      byte_shift <= 7'h00;
      payload_bit <= 3'h0;
    end else if (!instr_done) begin
      bit_count <= bit_count + 4'h1;
      instr_shift <= lsb_first ? instr_word[15:1] : instr_word[14:0];
      if (instr_last) begin
        instr_done <= 1'b1;
        is_read <= instr_word[serial_port_pkg::INSTR_RW_POS];
        addr <= instr_word[12:0];
      end
    end else begin
      payload_bit <= payload_bit + 3'h1;
      byte_shift <= lsb_first ? byte_word[7:1] : byte_word[6:0];
      if (byte_last) begin
        addr <= next_addr;
      end
    end
  end

  // ==========================================================================
  // completed write bytes handed to the system side, hold until next byte
  always_ff @(posedge serial_clock or negedge resetn) begin
    if (!resetn) begin
      wr_addr <= 13'h0000;
      wr_data <= 8'h00;
      wr_toggle <= 1'b0;
    end else if (write_byte) begin
      wr_addr <= addr;
      wr_data <= byte_word;
      wr_toggle <= ~wr_toggle;
    end
  end

  // ==========================================================================
  // port control registers live on the serial side
  always_ff @(posedge serial_clock or negedge resetn) begin
    if (!resetn) begin
      serial_port_config <= serial_port_pkg::SERIAL_PORT_CONFIG_RESET;
      readback_source_select <= serial_port_pkg::READBACK_SOURCE_SELECT_RESET;
    end else if (write_byte && is_config) begin
      serial_port_config <= byte_word;
    end else if (write_byte && is_select) begin
      readback_source_select <= byte_word;
    end
  end

  // ==========================================================================
  // read shifter, new bit after every falling edge
  always_ff @(negedge serial_clock or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      tx_shift <= 8'h00;
      tx_bit <= 1'b0;
      tx_active <= 1'b0;
    end else if (instr_done && is_read) begin
      tx_active <= 1'b1;
      if (payload_bit == 3'h0) begin
        tx_bit <= lsb_first ? rd_byte[0] : rd_byte[7];
        tx_shift <= lsb_first ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
      end else begin
        tx_bit <= lsb_first ? tx_shift[0] : tx_shift[7];
        tx_shift <= lsb_first ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // pin drivers, floated whenever select is high
  wire drive_enable = tx_active && !chip_select_n && port_enabled;
  assign sdio_out = tx_bit;
  assign serial_output_pin = tx_bit;
  assign sdio_oe = drive_enable && !four_wire;
  assign serial_output_oe = drive_enable && four_wire;

  // ==========================================================================
  // system side synchronisers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_sync <= 3'h0;
      select_sync <= 2'h3;
      update_sync <= 2'h0;
      update_seen <= 1'b0;
      strap_meta <= 4'h0;
      strap_sync <= 4'h0;
    end else if (clock_enable) begin
      wr_sync <= {wr_sync[1:0], wr_toggle};
      select_sync <= {select_sync[0], chip_select_n};
      update_sync <= {update_sync[0], update_pin};
      update_seen <= update_sync[1];
      strap_meta <= {strap_pin_d, strap_pin_c, strap_pin_b, strap_pin_a};
      strap_sync <= strap_meta;
    end
  end

  // ==========================================================================
  // strap capture once after reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_settle <= 2'h0;
      strap_done <= 1'b0;
      port_enabled <= 1'b0;
    end else if (clock_enable && !strap_done) begin
      strap_settle <= strap_settle + 2'h1;
      if (strap_settle == serial_port_pkg::STRAP_SETTLE_CYCLES) begin
        strap_done <= 1'b1;
        port_enabled <= strap_sync == serial_port_pkg::SERIAL_STRAP_PATTERN;
      end
    end
  end

  // ==========================================================================
  // write decode and update triggers
  wire wr_event = wr_sync[2] ^ wr_sync[1];
  wire [12:0] wr_offset = wr_addr - serial_port_pkg::SETTINGS_BASE_OFFSET;
  wire wr_in_settings = wr_addr >= serial_port_pkg::SETTINGS_BASE_OFFSET &&
    wr_offset < 13'(serial_port_pkg::SETTINGS_COUNT);
  wire [IDX_BITS-1:0] wr_index = wr_offset[IDX_BITS-1:0];
  wire commit_write = wr_event && port_enabled &&
    wr_addr == serial_port_pkg::BUFFER_COMMIT_TRIGGER_OFFSET &&
    wr_data[serial_port_pkg::COMMIT_POS];
  wire pin_edge = update_sync[1] && !update_seen;
  wire frame_closed = select_sync[1];
  // pin updates wait for an idle link so reads never see a moving value
  wire pin_commit = (update_pending || pin_edge) && frame_closed;
  wire commit = commit_write || pin_commit;

  // pending pin update, a new edge wins over the clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      update_pending <= 1'b0;
    end else if (clock_enable) begin
      update_pending <= pin_edge || (update_pending && !frame_closed);
    end
  end

  // ==========================================================================
  // buffered and active settings, one entry per generate step
  genvar i;
  generate
    for (i = 0; i < serial_port_pkg::SETTINGS_COUNT; i++) begin : g_entry
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          buffer_regs[i] <= serial_port_pkg::SETTINGS_RESET;
        end else if (clock_enable && wr_event && port_enabled && wr_in_settings &&
          wr_index == IDX_BITS'(i)) begin
          buffer_regs[i] <= wr_data;
        end
      end

      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          active_regs[i] <= serial_port_pkg::SETTINGS_RESET;
        end else if (clock_enable && commit) begin
          active_regs[i] <= buffer_regs[i];
        end
      end

      assign active_settings[i*8 +: 8] = active_regs[i];
    end
  endgenerate

endmodule

// ===== rtl/serial_port_pkg.sv
// constants for the serial register access port
// ==========================================================================
package serial_port_pkg;

  // ========================================================================
  // framing
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 13;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam int INSTR_RW_POS = 15;

  // ========================================================================
  // register offsets
  localparam logic [12:0] SERIAL_PORT_CONFIG_OFFSET = 13'h0000;
  localparam logic [12:0] READBACK_SOURCE_SELECT_OFFSET = 13'h0001;
  localparam logic [12:0] BUFFER_COMMIT_TRIGGER_OFFSET = 13'h000f;
  localparam logic [12:0] SETTINGS_BASE_OFFSET = 13'h0100;
  localparam int SETTINGS_COUNT = 16;

  // ========================================================================
  // field positions
  localparam int LSB_FIRST_POS = 6;
  localparam int ASCEND_POS = 5;
  localparam int FOUR_WIRE_POS = 4;
  localparam int READ_ACTIVE_POS = 5;
  localparam int COMMIT_POS = 0;

  // ========================================================================
  // values after reset
  localparam logic [7:0] SERIAL_PORT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] READBACK_SOURCE_SELECT_RESET = 8'h00;
  localparam logic [7:0] SETTINGS_RESET = 8'h00;

  // ========================================================================
  // strap decoding
  localparam logic [3:0] SERIAL_STRAP_PATTERN = 4'h0;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

endpackage

// ===== verif/serial_port_chk.sv
// assertion checker for the serial register access port
module serial_port_chk (
  // system side
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire logic strap_pin_a,
  input wire logic strap_pin_b,
  input wire logic strap_pin_c,
  input wire logic strap_pin_d,
  input wire logic port_enabled,
  input wire logic [127:0] active_settings,
  // link side
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_output_pin,
  input wire logic serial_output_oe
);
  logic [4:0] rises;
  // ==========================================================================
  // link edges seen in the current frame, saturating at sixteen
  always_ff @(posedge serial_clock or posedge chip_select_n) begin
    if (chip_select_n) begin
      rises <= 5'h00;
    end else if (rises != 5'h10) begin
      rises <= rises + 5'h01;
    end
  end
  sequence s_straps_serial;
    $rose(resetn) && clock_enable && !strap_pin_a && !strap_pin_b && !strap_pin_c && !strap_pin_d;
  endsequence
  sequence s_port_up;
    ##[1:8] port_enabled;
  endsequence
  // ==========================================================================
  // properties
  AST_CS_HIGH_FLOATS: assert property (@(posedge clock) disable iff (!resetn)
    chip_select_n |-> !sdio_oe && !serial_output_oe) else $error("pins driven while deselected");
  AST_ONE_PIN: assert property (@(posedge clock) disable iff (!resetn)
    !(sdio_oe && serial_output_oe)) else $error("both data pins driven");
  AST_SAME_BIT: assert property (@(posedge clock) disable iff (!resetn)
    (sdio_oe || serial_output_oe) |-> sdio_out == serial_output_pin) else $error("pins differ");
  AST_BIT_HOLDS: assert property (@(posedge clock) disable iff (!resetn)
    (serial_clock && $past(serial_clock) && serial_output_oe) |-> $stable(serial_output_pin))
    else $error("read bit moved while link clock high");
  AST_QUIET_IN_INSTR: assert property (@(posedge serial_clock)
    disable iff (chip_select_n || !resetn) (rises < 5'h10) |-> !sdio_oe && !serial_output_oe)
    else $error("drive during instruction");
  AST_PORT_UP: assert property (@(posedge clock) disable iff (!resetn)
    s_straps_serial |-> s_port_up) else $error("port not enabled after straps");
  AST_PORT_FIXED: assert property (@(posedge clock) disable iff (!resetn)
    port_enabled |=> port_enabled) else $error("port selection changed");
  AST_OFF_QUIET: assert property (@(posedge clock) disable iff (!resetn)
    !port_enabled |-> !sdio_oe && !serial_output_oe && active_settings == 128'h0)
    else $error("disabled port active");
endmodule

bind serial_register_access_port serial_port_chk i_chk (.clock(clock), .resetn(resetn),
  .clock_enable(clock_enable), .strap_pin_a(strap_pin_a), .strap_pin_b(strap_pin_b),
  .strap_pin_c(strap_pin_c), .strap_pin_d(strap_pin_d), .port_enabled(port_enabled),
  .active_settings(active_settings), .serial_clock(serial_clock),
  .chip_select_n(chip_select_n), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .serial_output_pin(serial_output_pin), .serial_output_oe(serial_output_oe));

// ===== verif/host_model.sv
// host model that masters the serial link
module host_model (
  // link outputs
  output logic serial_clock,
  output logic chip_select_n,
  output logic sdio_in,
  // device returns
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_output_pin,
  input wire logic serial_output_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv;
  logic hbit;
  logic idle;
  // released wire shows a toggling pattern, never the last bit
  assign sdio_in = sdio_oe ? sdio_out : (drv ? hbit : idle);
  // link clock stands low outside frames
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    drv = 1'b0;
    hbit = 1'b0;
    idle = 1'b0;
    forever #31.3 idle = ~idle;
  end
  // one frame: instruction, n bytes, then part stray bits
  task automatic xfer(input logic rd, input logic lsb, input logic [14:0] a, input int n,
    input int part, inout logic [7:0] d [4]);
    logic [15:0] w;
    int j;
    int p;
    w = {rd, a};
    chip_select_n = 1'b0;
    drv = 1'b1;
    for (int k = 0; k < 16 + n * 8 + part; k++) begin
      j = k - 16;
      p = lsb ? j % 8 : 7 - j % 8;
      if (k == 16) begin
        drv = !rd;
      end
      if (k < 16) begin
        hbit = lsb ? w[k] : w[15 - k];
      end else if (!rd) begin
        hbit = d[j / 8][p];
      end
      #22.5 serial_clock = 1'b1;
      if (rd && k >= 16) begin
        d[j / 8][p] = serial_output_oe ? serial_output_pin : sdio_in;
      end
      #62.5 serial_clock = 1'b0;
      #40;
    end
    chip_select_n = 1'b1;
    drv = 1'b0;
    #100;
  endtask
endmodule

// ===== verif/serial_register_access_port_tb.sv
// self-checking bench for the serial register access port
module serial_register_access_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [14:0] a; logic [7:0] w; logic [7:0] e;} row_type;
  logic clock, resetn, clock_enable, update_pin, serial_clock, chip_select_n, sdio_in;
  logic sdio_out, sdio_oe, serial_output_pin, serial_output_oe, port_enabled;
  logic [127:0] active_settings;
  logic [7:0] d [4];
  int n_fail = 0;
  int num_checks = 0;
  row_type rows [4] = '{'{15'h0100, 8'ha5, 8'ha5}, '{15'h610f, 8'h3c, 8'h3c},
    '{15'h0200, 8'h77, 8'h00}, '{15'h2105, 8'h5a, 8'h5a}};
  serial_register_access_port i_dut (.clock(clock), .resetn(resetn),
    .clock_enable(clock_enable), .strap_pin_a(1'b0), .strap_pin_b(1'b0), .strap_pin_c(1'b0),
    .strap_pin_d(1'b0), .update_pin(update_pin), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_output_pin(serial_output_pin), .serial_output_oe(serial_output_oe),
    .port_enabled(port_enabled), .active_settings(active_settings));
  host_model i_host (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_output_pin(serial_output_pin), .serial_output_oe(serial_output_oe));
  task chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // watchdog
  initial begin
    #1000000;
    n_fail++;
    end_sim();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    clock_enable = 1'b1;
    update_pin = 1'b0;
    repeat (10) @(posedge clock);
    #2 resetn = 1'b1;
    repeat (8) @(posedge clock);
    chk(port_enabled, 128'h1);
    foreach (rows[i]) begin
      d[0] = rows[i].w;
      i_host.xfer(1'b0, 1'b0, rows[i].a, 1, 0, d);
      i_host.xfer(1'b1, 1'b0, rows[i].a, 1, 0, d);
      chk(d[0], rows[i].e);
    end
    chk(active_settings, 128'h0);
    d[0] = 8'h01;
    i_host.xfer(1'b0, 1'b0, 15'h000f, 1, 0, d);
    #200;
    chk({active_settings[47:40], active_settings[7:0]}, 16'h5aa5);
    i_host.xfer(1'b1, 1'b0, 15'h000f, 1, 0, d);
    chk(d[0], 8'h00);
    d[0] = 8'h20;
    i_host.xfer(1'b0, 1'b0, 15'h0000, 1, 0, d);
    d = '{8'h11, 8'h22, 8'h33, 8'h44};
    i_host.xfer(1'b0, 1'b0, 15'h0102, 4, 0, d);
    i_host.xfer(1'b1, 1'b0, 15'h0102, 4, 0, d);
    chk({d[0], d[1], d[2], d[3]}, 32'h11223344);
    d[0] = 8'h20;
    i_host.xfer(1'b0, 1'b0, 15'h0001, 1, 0, d);
    i_host.xfer(1'b1, 1'b0, 15'h0105, 1, 0, d);
    chk(d[0], 8'h5a);
    d = '{8'h00, 8'h00, 8'h00, 8'h00};
    i_host.xfer(1'b0, 1'b0, 15'h0001, 2, 0, d);
    d = '{8'h66, 8'h77, 8'hff, 8'h00};
    i_host.xfer(1'b0, 1'b0, 15'h0109, 2, 5, d);
    i_host.xfer(1'b1, 1'b0, 15'h0109, 3, 0, d);
    chk({d[0], d[1], d[2]}, 24'h667700);
    d[0] = 8'h70;
    i_host.xfer(1'b0, 1'b0, 15'h0000, 1, 0, d);
    d = '{8'hc3, 8'h81, 8'h00, 8'h00};
    i_host.xfer(1'b0, 1'b1, 15'h010a, 2, 0, d);
    i_host.xfer(1'b1, 1'b1, 15'h010a, 2, 0, d);
    chk({d[0], d[1]}, 16'hc381);
    @(posedge clock);
    #2 update_pin = 1'b1;
    repeat (10) @(posedge clock);
    #2 update_pin = 1'b0;
    repeat (10) @(posedge clock);
    chk(active_settings[95:80], 16'h81c3);
    // reset in mid-run clears active copies and recaptures the straps
    @(posedge clock);
    #2 resetn = 1'b0;
    repeat (10) @(posedge clock);
    chk({port_enabled, active_settings}, 129'h0);
    #2 resetn = 1'b1;
    @(posedge clock);
    #2 chk(port_enabled, 128'h0);
    repeat (8) @(posedge clock);
    chk(port_enabled, 128'h1);
    end_sim();
  end
endmodule
